// ==== design/cwr_regs.sv ====
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
// Summary of operation
// - Five gain bits, each one feedback resistor; all zero enables none.
// - Any combination of the five sum-amp bits may be set together.
// - Each channel picks one of sixteen mixer phases on its own.
// - Channels 1-4 fill first phase register low nibble up; 5-8 second.
// - Phase code n means a shift of n times 22.5 degrees.
// - Five-bit termination field, each bit one resistor; zero is high Z.
module cwr_regs import cwr_pkg::*; (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [ADDR_W-1:0]        s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	output logic [RES_FIELD_W-1:0]        termination_feedback_pin_en,
	output logic [RES_FIELD_W-1:0]        sum_gain_resistor_en,
	output logic [NUM_CH*PHASE_W-1:0]     channel_mixer_phase_code
);
	// ****************************************************************
	// Address decode
	// ****************************************************************
	typedef enum logic [2:0] {
		CWR_W_IDLE = 3'b001,
		CWR_W_HAVE = 3'b010,
		CWR_W_RESP = 3'b100
	} cwr_wstate_t;

	function automatic logic [2:0] cwr_sel(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = a[ADDR_W-1:2];
		case (idx)
			IDX_TERM:     cwr_sel = 3'd1;
			IDX_SUM_GAIN: cwr_sel = 3'd2;
			IDX_PHASE_LO: cwr_sel = 3'd3;
			IDX_PHASE_HI: cwr_sel = 3'd4;
			default:      cwr_sel = 3'd0;
		endcase
	endfunction : cwr_sel

	// ****************************************************************
	// Write path
	// ****************************************************************
	cwr_wstate_t           wst_r, wst_nxt;
	logic                  aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [ADDR_W-1:0]     awa_r, awa_nxt;
	logic [31:0]           wd_r, wd_nxt;
	logic [3:0]            ws_r, ws_nxt;
	logic [1:0]            bresp_nxt;
	logic [REG_W-1:0]      term_r, term_nxt, gain_r, gain_nxt;
	logic [REG_W-1:0]      ph_lo_r, ph_lo_nxt, ph_hi_r, ph_hi_nxt;

	function automatic logic [15:0] cwr_merge(input logic [15:0] old,
			input logic [31:0] d, input logic [3:0] s);
		cwr_merge = old;
		if (s[0]) cwr_merge[7:0] = d[7:0];
		if (s[1]) cwr_merge[15:8] = d[15:8];
	endfunction : cwr_merge

	always_comb begin
		wst_nxt    = wst_r;
		aw_got_nxt = aw_got_r;
		w_got_nxt  = w_got_r;
		awa_nxt    = awa_r;
		wd_nxt     = wd_r;
		ws_nxt     = ws_r;
		bresp_nxt  = s_axi_bresp;
		term_nxt   = term_r;
		gain_nxt   = gain_r;
		ph_lo_nxt  = ph_lo_r;
		ph_hi_nxt  = ph_hi_r;
		case (wst_r)
			CWR_W_IDLE, CWR_W_HAVE: begin
				// Capture only on a real handshake, never on valid alone
				if (s_axi_awvalid && s_axi_awready) begin
					aw_got_nxt = 1'b1;
					awa_nxt    = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_got_nxt = 1'b1;
					wd_nxt    = s_axi_wdata;
					ws_nxt    = s_axi_wstrb;
				end
				wst_nxt = CWR_W_HAVE;
				if (aw_got_r && w_got_r) begin
					// Fields hold until software writes them again
					bresp_nxt = RESP_OKAY;
					case (cwr_sel(awa_r))
						3'd1: begin
							term_nxt = cwr_merge(term_r, wd_r, ws_r);
						end
						3'd2: begin
							gain_nxt = cwr_merge(gain_r, wd_r, ws_r);
						end
						3'd3: begin
							ph_lo_nxt = cwr_merge(ph_lo_r, wd_r, ws_r);
						end
						3'd4: begin
							ph_hi_nxt = cwr_merge(ph_hi_r, wd_r, ws_r);
						end
						default: bresp_nxt = RESP_SLVERR;
					endcase
					aw_got_nxt = 1'b0;
					w_got_nxt  = 1'b0;
					wst_nxt    = CWR_W_RESP;
				end
			end
			CWR_W_RESP: begin
				if (s_axi_bready) wst_nxt = CWR_W_IDLE;
			end
			default: wst_nxt = CWR_W_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_r         <= CWR_W_IDLE;
			aw_got_r      <= 1'b0;
			w_got_r       <= 1'b0;
			awa_r         <= '0;
			wd_r          <= 32'h00000000;
			ws_r          <= 4'h0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_bvalid  <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			term_r        <= RST_REG;
			gain_r        <= RST_REG;
			ph_lo_r       <= RST_REG;
			ph_hi_r       <= RST_REG;
		end else begin
			wst_r         <= wst_nxt;
			aw_got_r      <= aw_got_nxt;
			w_got_r       <= w_got_nxt;
			awa_r         <= awa_nxt;
			wd_r          <= wd_nxt;
			ws_r          <= ws_nxt;
			s_axi_bresp   <= bresp_nxt;
			s_axi_bvalid  <= (wst_nxt == CWR_W_RESP);
			// Ready is registered, so a channel is taken one cycle late
			s_axi_awready <= s_axi_awvalid && !aw_got_nxt && !s_axi_awready
				&& (wst_nxt != CWR_W_RESP);
			s_axi_wready  <= s_axi_wvalid && !w_got_nxt && !s_axi_wready
				&& (wst_nxt != CWR_W_RESP);
			term_r        <= term_nxt;
			gain_r        <= gain_nxt;
			ph_lo_r       <= ph_lo_nxt;
			ph_hi_r       <= ph_hi_nxt;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	logic        rv_nxt, ar_rdy_nxt;
	logic [31:0] rd_nxt;
	logic [1:0]  rr_nxt;

	always_comb begin
		rv_nxt     = s_axi_rvalid;
		rd_nxt     = s_axi_rdata;
		rr_nxt     = s_axi_rresp;
		ar_rdy_nxt = 1'b0;
		if (s_axi_rvalid) begin
			if (s_axi_rready) rv_nxt = 1'b0;
		end else if (s_axi_arready) begin
			rv_nxt = 1'b1;
			rr_nxt = RESP_OKAY;
			case (cwr_sel(s_axi_araddr))
				3'd1: rd_nxt = {16'h0000, term_r};
				3'd2: rd_nxt = {16'h0000, gain_r};
				3'd3: rd_nxt = {16'h0000, ph_lo_r};
				3'd4: rd_nxt = {16'h0000, ph_hi_r};
				default: begin
					rd_nxt = 32'h00000000;
					rr_nxt = RESP_SLVERR;
				end
			endcase
		end else begin
			ar_rdy_nxt = s_axi_arvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_rvalid  <= rv_nxt;
			s_axi_rdata   <= rd_nxt;
			s_axi_rresp   <= rr_nxt;
			s_axi_arready <= ar_rdy_nxt;
		end
	end

	// ****************************************************************
	// Static selection outputs
	// ****************************************************************
	// Phase code n selects n * 22.5 degree shift in the mixer clock logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			termination_feedback_pin_en <= '0;
			sum_gain_resistor_en        <= '0;
			channel_mixer_phase_code    <= '0;
		end else begin
			termination_feedback_pin_en <= term_r[RES_FIELD_W-1:0];
			sum_gain_resistor_en <= gain_r[RES_FIELD_W-1:0];
			channel_mixer_phase_code <=
				{ph_hi_r, ph_lo_r};
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_gain_write;
		wst_r != CWR_W_RESP && aw_got_r && w_got_r
			&& cwr_sel(awa_r) == 3'd2 && ws_r[0];
	endsequence

	a_gain_follows_write: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_gain_write |=> ##1 sum_gain_resistor_en == $past(wd_r[4:0], 2))
		else $error("gain enables do not follow write");
	a_gain_all_ones: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_gain_write ##0 wd_r[4:0] == 5'h1f
		|=> ##1 sum_gain_resistor_en == 5'h1f)
		else $error("all gain bits not set together");
	a_term_follows: assert property (
		@(posedge aclk) disable iff (!aresetn)
		##1 termination_feedback_pin_en == $past(term_r[4:0]))
		else $error("termination enables do not follow register");
	a_phase_ch1_low: assert property (
		@(posedge aclk) disable iff (!aresetn)
		##1 channel_mixer_phase_code[3:0] == $past(ph_lo_r[3:0]))
		else $error("channel one phase not in low nibble");
	a_phase_ch8_high: assert property (
		@(posedge aclk) disable iff (!aresetn)
		##1 channel_mixer_phase_code[31:28] == $past(ph_hi_r[15:12]))
		else $error("channel eight phase misplaced");
	a_phase_ch_indep: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && cwr_sel(awa_r) != 3'd3 && cwr_sel(awa_r) != 3'd4
		|-> $stable(ph_lo_r) && $stable(ph_hi_r))
		else $error("phase changed by unrelated write");
	a_fields_hold: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!(aw_got_r && w_got_r) |=> $stable(term_r) && $stable(gain_r))
		else $error("field changed without a write");
	a_bresp_follows: assert property (
		@(posedge aclk) disable iff (!aresetn)
		aw_got_r && w_got_r && wst_r != CWR_W_RESP |=> s_axi_bvalid)
		else $error("write response missing");
endmodule : cwr_regs

// ==== design/cwr_pkg.sv ====
package cwr_pkg;
	// ****************************************************************
	// Register map (indices; byte address is four times the index)
	// ****************************************************************
	localparam logic [7:0]  IDX_TERM      = 8'h34;
	localparam logic [7:0]  IDX_SUM_GAIN  = 8'h36;
	localparam logic [7:0]  IDX_PHASE_LO  = 8'h37;
	localparam logic [7:0]  IDX_PHASE_HI  = 8'h38;
	localparam int          ADDR_W        = 10;
	// ****************************************************************
	// Field layout and reset values
	// ****************************************************************
	localparam int          RES_FIELD_W   = 5;
	localparam int          PHASE_W       = 4;
	localparam int          NUM_CH        = 8;
	localparam int          CH_PER_REG    = 4;
	localparam int          REG_W         = 16;
	localparam logic [15:0] RST_REG       = 16'h0000;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
	// Phase step in hundredths of a degree
	localparam int          PHASE_STEP_CD = 2250;
endpackage : cwr_pkg

// ==== tb/cwr_regs_tb.sv ====
`timescale 1ns/10ps
module cwr_regs_tb import cwr_pkg::*;;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic                 aclk, aresetn;
	logic [ADDR_W-1:0]    awaddr, araddr;
	logic                 awvalid, awready, wvalid, wready, bvalid, bready;
	logic [31:0]          wdata, rdata;
	logic [3:0]           wstrb;
	logic [1:0]           bresp, rresp, r;
	logic                 arvalid, arready, rvalid, rready;
	logic [4:0]           term_en, gain_en;
	logic [31:0]          phase;
	logic [31:0]          d;
	logic [15:0]          lo, hi;
	int                   miscompares, n_checks;
	cwr_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.termination_feedback_pin_en(term_en),
		.sum_gain_resistor_en(gain_en), .channel_mixer_phase_code(phase));
	always #10 aclk = ~aclk;
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
			miscompares++;
		end
	endtask : check
	function automatic logic [9:0] ba(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction : ba
	// Leaves one idle edge before each request so no signal is set twice
	task automatic wr(input logic [9:0] a, input logic [31:0] dd,
			input logic [3:0] s, output logic [1:0] resp);
		int i;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= dd;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (i == 50) begin
			miscompares++;
			stop_test();
		end
		// Enables settle one cycle after the response
		repeat (2) @(posedge aclk);
		#1;
	endtask : wr
	task automatic rd(input logic [9:0] a, output logic [31:0] dd,
			output logic [1:0] resp);
		int i;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				dd = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (i == 50) begin
			miscompares++;
			stop_test();
		end
	endtask : rd
	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		aclk        = 1'b0;
		aresetn     = 1'b0;
		miscompares = 0;
		n_checks    = 0;
		awaddr      = '0;
		araddr      = '0;
		wdata       = '0;
		wstrb       = '0;
		awvalid     = 1'b0;
		wvalid      = 1'b0;
		bready      = 1'b0;
		arvalid     = 1'b0;
		rready      = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ba(IDX_TERM), d, r);
		check(d, 32'h0);
		rd(ba(IDX_PHASE_HI), d, r);
		check(d, 32'h0);
		check({term_en, gain_en, 22'h0}, 32'h0);
		check(phase, 32'h0);
		// Every gain code, each bit one resistor
		for (int c = 0; c < 32; c++) begin
			wr(ba(IDX_SUM_GAIN), 32'(c), 4'hf, r);
			check(32'(r), 32'(RESP_OKAY));
			check(32'(gain_en), 32'(c));
			rd(ba(IDX_SUM_GAIN), d, r);
			check(d, 32'(c));
			check(32'(r), 32'(RESP_OKAY));
		end
		// Upper bits kept as storage, only the field drives resistors
		wr(ba(IDX_TERM), 32'hffff_ffff, 4'hf, r);
		check(32'(term_en), 32'h1f);
		rd(ba(IDX_TERM), d, r);
		check(d, 32'h0000_ffff);
		wr(ba(IDX_TERM), 32'h15, 4'hf, r);
		check(32'(term_en), 32'h15);
		wr(ba(IDX_TERM), 32'h0, 4'hf, r);
		check(32'(term_en), 32'h0);
		check(32'(gain_en), 32'h1f);
		// Two passes give each channel its own code and cover all 16
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 4; k++) begin
				lo[4*k +: 4] = 4'(8*p + k);
				hi[4*k +: 4] = 4'(8*p + 4 + k);
			end
			wr(ba(IDX_PHASE_LO), {16'h0, lo}, 4'hf, r);
			wr(ba(IDX_PHASE_HI), {16'h0, hi}, 4'hf, r);
			check(phase, {hi, lo});
			rd(ba(IDX_PHASE_HI), d, r);
			check(d, {16'h0, hi});
		end
		// One byte lane only; other channels must stay put
		wr(ba(IDX_PHASE_LO), 32'h0000_00a5, 4'h1, r);
		check(phase, {hi, lo[15:8], 8'ha5});
		// Unmapped places answer with an error and change nothing
		wr(10'h000, 32'h0, 4'hf, r);
		check(32'(r), 32'(RESP_SLVERR));
		rd(10'h3fc, d, r);
		check(32'(r), 32'(RESP_SLVERR));
		check(d, 32'h0);
		check(32'(gain_en), 32'h1f);
		stop_test();
	end
endmodule : cwr_regs_tb
